//--- hdl/usbfc_dev.sv
// Device end: endpoint trigger, data-present and FIFO clear logic
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
// Functional notes
// R1 - Trigger bits are write-only one-shot pulses
// R2 - Bit 6 commits endpoint 3 packet
// R3 - Bit 5 frees only the read half
// R4 - Bit 4 commits endpoint 2 packet
// R5 - Bit 2 releases control data stage
// R6 - Data stage NACKed until bit 2 written
// R7 - Bit 1 frees control-out FIFO for next
// R8 - Bit 0 commits control-in packet
// R9 - Software writes zero to reserved bits
// R10 - Present set on commit, cleared when sent
// R11 - Present bits 5,4,0; others read zero
// R12 - Clear bit discards that FIFO's data
// R13 - FIFO clear leaves event flags alone
// R14 - Software never clears during transfer
// R15 - Clear bit 6 resets endpoint 3 FIFO
// R16 - Clear bit 5 resets both endpoint 1 halves
// R17 - Clear bit 4 resets both endpoint 2 halves
// R18 - Clear bits 1,0 reset endpoint 0 FIFOs
// R19 - Host ACK on control-in sets done flag
// R20 - Endpoint 1 receive sets full, reports size
// R21 - Zero bits ignored, ones act independently
module usbfc_dev (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	usbfc_link_if.dev        link,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest
);
	import usbfc_pkg::*;

	logic        wait_reg, wr_ok, ack_in, tok_out, tok_in;
	logic        setup_lock_reg, await_reg, cout_full_reg, hs_valid_reg;
	logic        cin_pres, bin_pres, iin_pres, cin_rdy, bin_rdy, iin_rdy;
	logic        bout_wr_reg, bout_rd_reg;
	logic [1:0]  await_ep_reg, bout_full_reg;
	logic [7:0]  trig, clr, cout_len_reg, hs_len_reg;
	logic [7:0]  cin_len, bin_len, iin_len;
	logic [7:0]  bout_len_reg [2];
	logic [31:0] rdata_reg;
	logic [USBFC_E_BITS-1:0] ev_reg, ev_set, ev_clr;
	usbfc_hs_t   hs_code_reg;

	// Write decode helper for the write-only strobe registers and the event clear
	function automatic logic [7:0] strobe(input logic [3:0] a);
		strobe = (wr_ok && avs_address == a) ? avs_writedata[7:0] : 8'h00;
	endfunction : strobe

	// ********************************************************************
	// Avalon-MM slave: one wait cycle, then a single answer cycle
	// ********************************************************************
	assign avs_waitrequest = wait_reg;
	assign avs_readdata    = rdata_reg;
	assign wr_ok = avs_write && !wait_reg;
	// A process, so the strobes follow the bus and not only the args
	always_comb begin
		trig   = strobe(USBFC_A_TRIGGER); // [R1] [R21]
		clr    = strobe(USBFC_A_CLEAR); // [R12] [R21]
		ev_clr = USBFC_E_BITS'(strobe(USBFC_A_EVENTS));
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 1'b1;
		end else begin
			wait_reg <= !(wait_reg && (avs_read || avs_write));
		end
	end

	// Read mux; write-only and unmapped words read zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= USBFC_RD_ZERO;
		end else if (avs_read && wait_reg) begin
			rdata_reg <= USBFC_RD_ZERO; // [R1]
			unique case (avs_address)
				USBFC_A_PRESENT: begin
					rdata_reg[USBFC_B_IIN_DP] <= iin_pres; // [R11]
					rdata_reg[USBFC_B_BIN_DP] <= bin_pres; // [R11]
					rdata_reg[USBFC_B_CIN_DP] <= cin_pres; // [R11]
				end
				USBFC_A_EVENTS: rdata_reg[USBFC_E_BITS-1:0] <= ev_reg;
				USBFC_A_RX_SIZE: begin
					rdata_reg[7:0] <= cout_len_reg;
					rdata_reg[USBFC_SZ_BOUT_LSB +: 8] <=
						bout_len_reg[bout_rd_reg]; // [R20]
				end
				default: ;
			endcase
		end
	end

	// ********************************************************************
	// Transmit buffers for endpoints 0 in, 2 and 3
	// ********************************************************************
	assign ack_in = link.tok_valid && link.tok_pid == USBFC_PID_ACK
		&& await_reg;

	usbfc_tx_buf #(.HALVES(1), .MAXLEN(USBFC_EP0_MAX)) u_cin (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.byte_wr  (wr_ok && avs_address == USBFC_A_CIN_DATA),
		.commit   (trig[USBFC_B_CIN_COMMIT]), // [R8]
		.clear    (clr[USBFC_B_CIN_CLR]), // [R18]
		.sent_ack (ack_in && await_ep_reg == USBFC_EP0),
		.present  (cin_pres),
		.ready    (cin_rdy),
		.tx_len   (cin_len)
	);

	usbfc_tx_buf #(.HALVES(2), .MAXLEN(USBFC_EP2_MAX)) u_bin (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.byte_wr  (wr_ok && avs_address == USBFC_A_BIN_DATA),
		.commit   (trig[USBFC_B_BIN_COMMIT]), // [R4]
		.clear    (clr[USBFC_B_BIN_CLR]), // [R17]
		.sent_ack (ack_in && await_ep_reg == USBFC_EP2),
		.present  (bin_pres),
		.ready    (bin_rdy),
		.tx_len   (bin_len)
	);

	usbfc_tx_buf #(.HALVES(1), .MAXLEN(USBFC_EP3_MAX)) u_iin (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.byte_wr  (wr_ok && avs_address == USBFC_A_IIN_DATA),
		.commit   (trig[USBFC_B_IIN_COMMIT]), // [R2]
		.clear    (clr[USBFC_B_IIN_CLR]), // [R15]
		.sent_ack (ack_in && await_ep_reg == USBFC_EP3),
		.present  (iin_pres),
		.ready    (iin_rdy),
		.tx_len   (iin_len)
	);

	// ********************************************************************
	// Setup lock and pending IN acknowledge
	// ********************************************************************
	assign tok_out = link.tok_valid && link.tok_pid == USBFC_PID_OUT;
	assign tok_in  = link.tok_valid && link.tok_pid == USBFC_PID_IN;

	// A new setup relocks even if software releases in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			setup_lock_reg <= 1'b0;
		end else if (link.tok_valid && link.tok_pid == USBFC_PID_SETUP) begin
			setup_lock_reg <= 1'b1;
		end else if (trig[USBFC_B_SETUP_DONE]) begin
			setup_lock_reg <= 1'b0; // [R5]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			await_reg    <= 1'b0;
			await_ep_reg <= USBFC_EP0;
		end else if (link.tok_valid) begin
			await_reg    <= hs_data_ok(link.tok_ep) && tok_in;
			await_ep_reg <= link.tok_ep;
		end
	end

	// IN is served when the endpoint has a committed half to send and, on endpoint 0, the setup lock is released
	function automatic logic hs_data_ok(input logic [1:0] ep);
		unique case (ep)
			USBFC_EP0: hs_data_ok = cin_rdy && !setup_lock_reg; // [R6]
			USBFC_EP2: hs_data_ok = bin_rdy;
			USBFC_EP3: hs_data_ok = iin_rdy;
			default:   hs_data_ok = 1'b0;
		endcase
	endfunction : hs_data_ok

	// ********************************************************************
	// Receive side: control-out single, bulk-out dual half
	// ********************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cout_full_reg <= 1'b0;
			cout_len_reg  <= USBFC_LEN_ZERO;
		end else if (clr[USBFC_B_COUT_CLR]) begin
			cout_full_reg <= 1'b0; // [R18]
			cout_len_reg  <= USBFC_LEN_ZERO;
		end else if (ev_set[USBFC_E_COUT]) begin
			cout_full_reg <= 1'b1;
			cout_len_reg  <= link.tok_len;
		end else if (trig[USBFC_B_COUT_DONE]) begin
			cout_full_reg <= 1'b0; // [R7]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bout_full_reg   <= 2'h0;
			bout_len_reg[0] <= USBFC_LEN_ZERO;
			bout_len_reg[1] <= USBFC_LEN_ZERO;
			bout_wr_reg     <= 1'b0;
			bout_rd_reg     <= 1'b0;
		end else if (clr[USBFC_B_BOUT_CLR]) begin
			bout_full_reg <= 2'h0; // [R16]
			bout_wr_reg   <= 1'b0;
			bout_rd_reg   <= 1'b0;
		end else begin
			if (ev_set[USBFC_E_BOUT_FULL]) begin
				bout_full_reg[bout_wr_reg] <= 1'b1; // [R20]
				bout_len_reg[bout_wr_reg]  <= link.tok_len;
				bout_wr_reg                <= ~bout_wr_reg;
			end
			// Only the half just read is released
			if (trig[USBFC_B_BOUT_DONE] && bout_full_reg[bout_rd_reg]) begin
				bout_full_reg[bout_rd_reg] <= 1'b0; // [R3]
				bout_rd_reg                <= ~bout_rd_reg;
			end
		end
	end

	// ********************************************************************
	// Sticky event flags, write one to clear, set wins
	// ********************************************************************
	always_comb begin
		ev_set = '0;
		ev_set[USBFC_E_CIN_DONE] = ack_in && await_ep_reg == USBFC_EP0; // [R19]
		ev_set[USBFC_E_IIN_DONE] = ack_in && await_ep_reg == USBFC_EP3;
		ev_set[USBFC_E_SETUP] = link.tok_valid
			&& link.tok_pid == USBFC_PID_SETUP;
		ev_set[USBFC_E_COUT] = tok_out && link.tok_ep == USBFC_EP0
			&& !setup_lock_reg && !cout_full_reg;
		ev_set[USBFC_E_BOUT_FULL] = tok_out && link.tok_ep == USBFC_EP1
			&& !bout_full_reg[bout_wr_reg]; // [R20]
	end

	// The clear register has no path here, so flags survive it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ev_reg <= '0;
		end else begin
			ev_reg <= ev_set | (ev_reg & ~ev_clr); // [R13]
		end
	end

	// ********************************************************************
	// Handshake answer, registered, one cycle after the token
	// ********************************************************************
	assign link.hs_valid = hs_valid_reg;
	assign link.hs_code  = hs_code_reg;
	assign link.hs_len   = hs_len_reg;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hs_valid_reg <= 1'b0;
			hs_code_reg  <= USBFC_HS_NACK;
			hs_len_reg   <= USBFC_BYTE_ZERO;
		end else begin
			hs_valid_reg <= link.tok_valid && link.tok_pid != USBFC_PID_ACK;
			hs_len_reg   <= USBFC_BYTE_ZERO;
			hs_code_reg  <= USBFC_HS_NACK;
			if (link.tok_pid == USBFC_PID_SETUP) begin
				hs_code_reg <= USBFC_HS_ACK;
			end else if (tok_in && hs_data_ok(link.tok_ep)) begin
				hs_code_reg <= USBFC_HS_DATA;
				unique case (link.tok_ep)
					USBFC_EP0: hs_len_reg <= cin_len;
					USBFC_EP2: hs_len_reg <= bin_len;
					default:   hs_len_reg <= iin_len;
				endcase
			end else if (ev_set[USBFC_E_COUT] || ev_set[USBFC_E_BOUT_FULL]) begin
				hs_code_reg <= USBFC_HS_ACK;
			end
		end
	end
endmodule : usbfc_dev

//--- hdl/usbfc_pkg.sv
// Shared constants and types of the endpoint FIFO control block and its link
package usbfc_pkg;

	// ********************************************************************
	// Link encodings
	// ********************************************************************
	typedef enum logic [1:0] {
		USBFC_PID_SETUP = 2'h0,
		USBFC_PID_OUT   = 2'h1,
		USBFC_PID_IN    = 2'h2,
		USBFC_PID_ACK   = 2'h3
	} usbfc_pid_t;

	typedef enum logic [1:0] {
		USBFC_HS_ACK  = 2'h0,
		USBFC_HS_NACK = 2'h1,
		USBFC_HS_DATA = 2'h2
	} usbfc_hs_t;

	localparam logic [1:0] USBFC_EP0 = 2'h0;
	localparam logic [1:0] USBFC_EP1 = 2'h1;
	localparam logic [1:0] USBFC_EP2 = 2'h2;
	localparam logic [1:0] USBFC_EP3 = 2'h3;

	// ********************************************************************
	// Packet sizes
	// ********************************************************************
	localparam logic [7:0] USBFC_EP0_MAX = 8'h08;
	localparam logic [7:0] USBFC_EP2_MAX = 8'h40;
	localparam logic [7:0] USBFC_EP3_MAX = 8'h08;
	localparam logic [7:0] USBFC_LEN_ZERO = 8'h00;
	localparam logic [7:0] USBFC_LEN_ONE  = 8'h01;

	// ********************************************************************
	// Register word addresses
	// ********************************************************************
	localparam logic [3:0] USBFC_A_TRIGGER   = 4'h0;
	localparam logic [3:0] USBFC_A_PRESENT   = 4'h1;
	localparam logic [3:0] USBFC_A_CLEAR     = 4'h2;
	localparam logic [3:0] USBFC_A_CIN_DATA  = 4'h3;
	localparam logic [3:0] USBFC_A_BIN_DATA  = 4'h4;
	localparam logic [3:0] USBFC_A_IIN_DATA  = 4'h5;
	localparam logic [3:0] USBFC_A_EVENTS    = 4'h6;
	localparam logic [3:0] USBFC_A_RX_SIZE   = 4'h7;

	// ********************************************************************
	// Bit positions (trigger, clear, present, events)
	// ********************************************************************
	localparam int USBFC_B_IIN_COMMIT = 6;
	localparam int USBFC_B_BOUT_DONE  = 5;
	localparam int USBFC_B_BIN_COMMIT = 4;
	localparam int USBFC_B_SETUP_DONE = 2;
	localparam int USBFC_B_COUT_DONE  = 1;
	localparam int USBFC_B_CIN_COMMIT = 0;
	localparam int USBFC_B_IIN_CLR    = 6;
	localparam int USBFC_B_BOUT_CLR   = 5;
	localparam int USBFC_B_BIN_CLR    = 4;
	localparam int USBFC_B_COUT_CLR   = 1;
	localparam int USBFC_B_CIN_CLR    = 0;
	localparam int USBFC_B_IIN_DP     = 5;
	localparam int USBFC_B_BIN_DP     = 4;
	localparam int USBFC_B_CIN_DP     = 0;
	localparam int USBFC_E_CIN_DONE   = 0;
	localparam int USBFC_E_SETUP      = 1;
	localparam int USBFC_E_COUT       = 2;
	localparam int USBFC_E_BOUT_FULL  = 3;
	localparam int USBFC_E_IIN_DONE   = 4;
	localparam int USBFC_E_BITS       = 5;
	localparam int USBFC_SZ_BOUT_LSB  = 8;

	localparam logic [31:0] USBFC_RD_ZERO = 32'h0000_0000;
	localparam logic [7:0]  USBFC_BYTE_ZERO = 8'h00;

endpackage : usbfc_pkg

//--- hdl/usbfc_link_if.sv
// Transaction-level link between the function controller and the host
`timescale 1ns/10ps
interface usbfc_link_if;
	import usbfc_pkg::*;

	// Host to device token, one-cycle pulse
	logic       tok_valid;
	usbfc_pid_t tok_pid;
	logic [1:0] tok_ep;
	logic [7:0] tok_len;
	// Device to host handshake, one-cycle pulse
	logic       hs_valid;
	usbfc_hs_t  hs_code;
	logic [7:0] hs_len;

	modport dev (
		input  tok_valid,
		input  tok_pid,
		input  tok_ep,
		input  tok_len,
		output hs_valid,
		output hs_code,
		output hs_len
	);

	modport host (
		output tok_valid,
		output tok_pid,
		output tok_ep,
		output tok_len,
		input  hs_valid,
		input  hs_code,
		input  hs_len
	);
endinterface : usbfc_link_if

//--- hdl/usbfc_tx_buf.sv
// Transmit packet buffer bookkeeping, single or dual half
`timescale 1ns/10ps
module usbfc_tx_buf #(
	parameter int         HALVES = 1,
	parameter logic [7:0] MAXLEN = 8'h08
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       byte_wr,
	input  wire logic       commit,
	input  wire logic       clear,
	input  wire logic       sent_ack,
	output logic            present,
	output logic            ready,
	output logic [7:0]      tx_len
);
	import usbfc_pkg::*;

	logic [7:0] fill_reg;
	logic [1:0] valid_reg;
	logic [7:0] len_reg [2];
	logic       wr_sel_reg;
	logic       rd_sel_reg;
	logic       dual;

	assign dual    = (HALVES == 2);
	assign present = |valid_reg;
	assign ready   = valid_reg[rd_sel_reg];
	assign tx_len  = len_reg[rd_sel_reg];

	// ********************************************************************
	// Fill count of the half being written
	// ********************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fill_reg <= USBFC_LEN_ZERO;
		end else if (clear) begin
			fill_reg <= USBFC_LEN_ZERO; // [R12]
		end else if (commit && !valid_reg[wr_sel_reg]) begin
			fill_reg <= USBFC_LEN_ZERO;
		end else if (byte_wr && fill_reg != MAXLEN) begin
			fill_reg <= fill_reg + USBFC_LEN_ONE;
		end
	end

	// Half flags; clear wipes both halves and both pointers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			valid_reg  <= 2'h0;
			len_reg[0] <= USBFC_LEN_ZERO;
			len_reg[1] <= USBFC_LEN_ZERO;
			wr_sel_reg <= 1'b0;
			rd_sel_reg <= 1'b0;
		end else if (clear) begin
			valid_reg  <= 2'h0; // [R15] [R17] [R18]
			wr_sel_reg <= 1'b0;
			rd_sel_reg <= 1'b0;
		end else begin
			// Commit fixes the written half and swaps when dual
			if (commit && !valid_reg[wr_sel_reg]) begin
				valid_reg[wr_sel_reg] <= 1'b1; // [R2] [R4] [R8] [R10]
				len_reg[wr_sel_reg]   <= fill_reg;
				wr_sel_reg            <= dual ? ~wr_sel_reg : wr_sel_reg;
			end
			// Host ACK retires the half that was sent
			if (sent_ack && valid_reg[rd_sel_reg]) begin
				valid_reg[rd_sel_reg] <= 1'b0; // [R10]
				rd_sel_reg            <= dual ? ~rd_sel_reg : rd_sel_reg;
			end
		end
	end
endmodule : usbfc_tx_buf

//--- hdl/usbfc_host.sv
// Host end: issues one token, waits for the answer, acknowledges data
`timescale 1ns/10ps
module usbfc_host (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	usbfc_link_if.host                 link,
	input  wire logic                  cmd_valid,
	input  usbfc_pkg::usbfc_pid_t      cmd_pid,
	input  wire logic [1:0]            cmd_ep,
	input  wire logic [7:0]            cmd_len,
	output logic                       cmd_ready,
	output logic                       res_valid,
	output usbfc_pkg::usbfc_hs_t       res_code,
	output logic [7:0]                 res_len
);
	import usbfc_pkg::*;

	typedef enum logic [1:0] {
		USBFC_H_IDLE = 2'h0,
		USBFC_H_WAIT = 2'h1,
		USBFC_H_ACK  = 2'h2
	} usbfc_hstate_t;

	usbfc_hstate_t state_reg;
	logic          tok_valid_reg;
	usbfc_pid_t    tok_pid_reg;
	logic [1:0]    tok_ep_reg;
	logic [7:0]    tok_len_reg;
	logic          res_valid_reg;
	usbfc_hs_t     res_code_reg;
	logic [7:0]    res_len_reg;

	assign link.tok_valid = tok_valid_reg;
	assign link.tok_pid   = tok_pid_reg;
	assign link.tok_ep    = tok_ep_reg;
	assign link.tok_len   = tok_len_reg;
	assign cmd_ready      = (state_reg == USBFC_H_IDLE) && !tok_valid_reg;
	assign res_valid      = res_valid_reg;
	assign res_code       = res_code_reg;
	assign res_len        = res_len_reg;

	// ********************************************************************
	// Transaction sequencer
	// ********************************************************************
	// ACK tokens from the user are not sent; the host makes its own
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg     <= USBFC_H_IDLE;
			tok_valid_reg <= 1'b0;
			tok_pid_reg   <= USBFC_PID_SETUP;
			tok_ep_reg    <= USBFC_EP0;
			tok_len_reg   <= USBFC_BYTE_ZERO;
		end else begin
			tok_valid_reg <= 1'b0;
			unique case (state_reg)
				USBFC_H_IDLE: begin
					if (cmd_valid && cmd_ready && cmd_pid != USBFC_PID_ACK) begin
						tok_valid_reg <= 1'b1;
						tok_pid_reg   <= cmd_pid;
						tok_ep_reg    <= cmd_ep;
						tok_len_reg   <= cmd_len;
						state_reg     <= USBFC_H_WAIT;
					end
				end
				USBFC_H_WAIT: begin
					if (link.hs_valid) begin
						state_reg <= (link.hs_code == USBFC_HS_DATA) ?
							USBFC_H_ACK : USBFC_H_IDLE;
					end
				end
				USBFC_H_ACK: begin
					tok_valid_reg <= 1'b1; // [R19]
					tok_pid_reg   <= USBFC_PID_ACK;
					state_reg     <= USBFC_H_IDLE;
				end
				default: begin
					state_reg <= USBFC_H_IDLE;
				end
			endcase
		end
	end

	// Result pulse one cycle after the device answers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			res_valid_reg <= 1'b0;
			res_code_reg  <= USBFC_HS_NACK;
			res_len_reg   <= USBFC_BYTE_ZERO;
		end else begin
			res_valid_reg <= (state_reg == USBFC_H_WAIT) && link.hs_valid;
			if ((state_reg == USBFC_H_WAIT) && link.hs_valid) begin
				res_code_reg <= link.hs_code;
				res_len_reg  <= link.hs_len;
			end
		end
	end
endmodule : usbfc_host

//--- tb/usbfc_link_asserts.sv
// Link checker for the endpoint FIFO control ends
`timescale 1ns/10ps
module usbfc_link_chk (
	input  wire logic            clk_sys,
	input  wire logic            rst_n,
	input  wire logic            tok_valid,
	input  usbfc_pkg::usbfc_pid_t tok_pid,
	input  wire logic [1:0]      tok_ep,
	input  wire logic [7:0]      tok_len,
	input  wire logic            hs_valid,
	input  usbfc_pkg::usbfc_hs_t hs_code,
	input  wire logic [7:0]      hs_len
);
	import usbfc_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	logic tok_req;
	logic hs_data;
	// ACK tokens close a transfer and expect no answer
	assign tok_req = tok_valid && (tok_pid != USBFC_PID_ACK);
	assign hs_data = hs_valid && (hs_code == USBFC_HS_DATA);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_token_answered: assert property (tok_req |=> hs_valid)
		else $error("token got no handshake");
	a_answer_caused: assert property (hs_valid |-> $past(tok_req))
		else $error("handshake without token");
	a_ack_silent: assert property (
		tok_valid && tok_pid == USBFC_PID_ACK |=> !hs_valid)
		else $error("handshake after ack token");
	a_data_for_in: assert property (
		hs_data |-> $past(tok_pid) == USBFC_PID_IN)
		else $error("data answer without in token");
	a_out_tx_nack: assert property (
		tok_valid && tok_pid == USBFC_PID_OUT && tok_ep[1]
		|=> hs_code == USBFC_HS_NACK)
		else $error("out token to transmit endpoint accepted");
	a_in_rx_nack: assert property (
		tok_valid && tok_pid == USBFC_PID_IN && tok_ep == USBFC_EP1
		|=> hs_valid && hs_code == USBFC_HS_NACK)
		else $error("in token to receive endpoint accepted");
	a_setup_acked: assert property (
		tok_valid && tok_pid == USBFC_PID_SETUP
		|=> hs_valid && hs_code == USBFC_HS_ACK)
		else $error("setup token not acknowledged");
	a_data_len_max: assert property (
		hs_data |-> hs_len <= (($past(tok_ep) == USBFC_EP2)
		? USBFC_EP2_MAX : USBFC_EP0_MAX))
		else $error("data answer longer than packet size");
	a_host_acks_data: assert property (
		hs_data |-> ##2 tok_valid && tok_pid == USBFC_PID_ACK)
		else $error("host did not acknowledge data");

	// Main scenarios reached
	c_data_answer: cover property (hs_data);
	c_nack_answer: cover property (hs_valid && hs_code == USBFC_HS_NACK);
	c_setup_token: cover property (tok_valid && tok_pid == USBFC_PID_SETUP);
endmodule : usbfc_link_chk

//--- tb/tb_usb_endpoint_fifo_control.sv
// Self-checking bench for both ends of the endpoint FIFO control link
`timescale 1ns/10ps
module tb_usb_endpoint_fifo_control;
	import usbfc_pkg::*;

	logic        clk_sys;
	logic        rst_n;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        cmd_valid;
	usbfc_pid_t  cmd_pid;
	logic [1:0]  cmd_ep;
	logic [7:0]  cmd_len;
	logic        cmd_ready;
	logic        res_valid;
	usbfc_hs_t   res_code;
	logic [7:0]  res_len;
	int          n_mismatch;
	int          n_checks;

	// ****************************************************************
	// Rows: kind, addr or pid/ep, byte, expected (16 bits)
	// ****************************************************************
	// Kind 0 write, 1 read and compare, 2 host command
	// Reserved trigger and clear bits are always written as zero
	// FIFO clears are only written while the link is idle
	logic [31:0] rows [$] = '{
		32'h03110000, 32'h03220000, 32'h03330000, 32'h28000100,
		32'h11000000, 32'h00010000, 32'h11000001, 32'h28000203,
		32'h11000000, 32'h16000001, 32'h061f0000, 32'h04aa0000,
		32'h04bb0000, 32'h00100000, 32'h04cc0000, 32'h00100000,
		32'h11000010, 32'h2a000202, 32'h11000010, 32'h2a000201,
		32'h11000000, 32'h2a000100, 32'h05dd0000, 32'h03ee0000,
		32'h03ef0000, 32'h00410000, 32'h11000021, 32'h00000000,
		32'h2b000201, 32'h28000202, 32'h11000000, 32'h16000011,
		32'h00010000, 32'h20080000, 32'h28000100, 32'h24040100,
		32'h00040000, 32'h24040000, 32'h17000004, 32'h28000200,
		32'h24030100, 32'h00020000, 32'h24030000, 32'h17000003,
		32'h02020000, 32'h24050000, 32'h17000005, 32'h16000017,
		32'h25050000, 32'h25060000, 32'h25070100, 32'h1600001f,
		32'h17000505, 32'h00200000, 32'h17000605, 32'h25070000,
		32'h25010100, 32'h02200000, 32'h1600001f, 32'h25020000,
		32'h25030000, 32'h25040100, 32'h26010100, 32'h29000100,
		32'h03010000, 32'h00010000, 32'h02010000, 32'h11000000,
		32'h28000100, 32'h05020000, 32'h00400000, 32'h11000020,
		32'h02400000, 32'h11000000, 32'h04010000, 32'h00100000,
		32'h04020000, 32'h00100000, 32'h02100000, 32'h11000000,
		32'h2a000100, 32'h10000000, 32'h12000000, 32'h01ff0000,
		32'h11000000, 32'h0fff0000, 32'h1f000000
	};

	// ****************************************************************
	// Design and checker
	// ****************************************************************
	usbfc_link_if usbfc_link_if_i ();

	usbfc_dev usbfc_dev_i (
		.clk_sys         (clk_sys),
		.rst_n           (rst_n),
		.link            (usbfc_link_if_i),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest)
	);

	usbfc_host usbfc_host_i (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.link      (usbfc_link_if_i),
		.cmd_valid (cmd_valid),
		.cmd_pid   (cmd_pid),
		.cmd_ep    (cmd_ep),
		.cmd_len   (cmd_len),
		.cmd_ready (cmd_ready),
		.res_valid (res_valid),
		.res_code  (res_code),
		.res_len   (res_len)
	);

	usbfc_link_chk usbfc_link_chk_i (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.tok_valid (usbfc_link_if_i.tok_valid),
		.tok_pid   (usbfc_link_if_i.tok_pid),
		.tok_ep    (usbfc_link_if_i.tok_ep),
		.tok_len   (usbfc_link_if_i.tok_len),
		.hs_valid  (usbfc_link_if_i.hs_valid),
		.hs_code   (usbfc_link_if_i.hs_code),
		.hs_len    (usbfc_link_if_i.hs_len)
	);

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task stop_test;
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	task cmp(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask : cmp

	// Request held until waitrequest is sampled low at an edge
	task av_xfer(input logic [3:0] a, input logic rd,
		input logic [31:0] wd, output logic [31:0] q);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= wd;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			n_mismatch++;
			stop_test();
		end
	endtask : av_xfer

	// Length of the answer is only defined for data answers
	task host_cmd(input logic [31:0] r);
		int n;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_pid <= usbfc_pid_t'(r[27:26]);
		cmd_ep <= r[25:24];
		cmd_len <= r[23:16];
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (cmd_ready !== 1'b1 && n < 50);
		cmd_valid <= 1'b0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (res_valid !== 1'b1 && n < 100);
		if (n >= 100) begin
			n_mismatch++;
			stop_test();
		end
		cmp({30'h0, res_code}, {24'h0, r[15:8]});
		if (r[15:8] == 8'h02)
			cmp({24'h0, res_len}, {24'h0, r[7:0]});
	endtask : host_cmd

	task run_row(input logic [31:0] r);
		logic [31:0] d;
		if (r[31:28] == 4'h2)
			host_cmd(r);
		else if (r[31:28] == 4'h1) begin
			av_xfer(r[27:24], 1'b1, 32'h0000_0000, d);
			cmp(d, {16'h0000, r[15:0]});
		end else
			av_xfer(r[27:24], 1'b0, {24'h0, r[23:16]}, d);
	endtask : run_row

	// ****************************************************************
	// Clock and main sequence
	// ****************************************************************
	always #50 clk_sys = ~clk_sys;

	initial begin
		clk_sys = 1'b0;
		rst_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		cmd_valid = 1'b0;
		cmd_pid = USBFC_PID_SETUP;
		cmd_ep = 2'h0;
		cmd_len = 8'h00;
		n_mismatch = 0;
		n_checks = 0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		foreach (rows[i])
			run_row(rows[i]);
		// Reset in mid-run drops a committed packet and the full control-out buffer
		run_row(32'h05010000);
		run_row(32'h00400000);
		run_row(32'h11000020);
		run_row(32'h061f0000);
		run_row(32'h16000000);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		run_row(32'h11000000);
		run_row(32'h24020000);
		run_row(32'h2b000100);
		stop_test();
	end
endmodule : tb_usb_endpoint_fifo_control
